/* logic/tras_pkg.sv */
// Operation
// - loop-up flag while loop-up code received
// - loop-down flag while loop-down code received
// - transmit clock loss after 5.2 us idle
// - clock loss drives shared pin when enabled
// - clock loss moves transmit to receive clock
// - slip flag on elastic store repeat/delete
// - blue set: five or fewer zeros/3 ms
// - blue clear: six or more zeros/3 ms
// - blue robust to errors, framed ones
// - bit-2 yellow: 254 of 256 zero
// - twelfth F-bit yellow: two consecutive
// - ESF yellow: 16 set, 14-of-16 clear
// - red set after 192 consecutive zeros
// - red clear: 14 ones in 112 bits
// - framer carrier loss follows red criteria
package tras_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_COMMON_CTRL = 8'h70;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h71;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h72;
  localparam logic [7:0] ADDR_LOOP_UP = 8'h73;
  localparam logic [7:0] ADDR_LOOP_DOWN = 8'h74;
  localparam logic [7:0] ADDR_LOOP_LEN = 8'h75;

  // status bit positions
  localparam int ST_LOOP_UP = 7;
  localparam int ST_LOOP_DOWN = 6;
  localparam int ST_TX_CLK_LOSS = 5;
  localparam int ST_SLIP = 4;
  localparam int ST_BLUE = 3;
  localparam int ST_YELLOW = 2;
  localparam int ST_CARRIER = 1;
  localparam int ST_SYNC = 0;

  // control bit positions
  localparam int CC_PIN_CLK_LOSS = 6;
  localparam int TC_FALLBACK = 7;
  localparam int RC_YEL_F12 = 2;
  localparam int RC_ESF = 3;
  localparam int LL_UP_LSB = 0;
  localparam int LL_DOWN_LSB = 3;

  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_LOOP_CODE = 8'h00;
  localparam logic [7:0] RST_LOOP_LEN = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TX_LOSS_NS = 5200;
  localparam int TX_LOSS_CYC = (TX_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLUE_WIN_NS = 3000000;
  localparam int BLUE_WIN_CYC = BLUE_WIN_NS / CLK_PERIOD_NS;
  localparam int LOOP_RUN_BITS = 48;

  // alarm thresholds
  localparam int BLUE_SET_MAX_ZEROS = 5;
  localparam int YEL_CHANS = 256;
  localparam int YEL_MIN_ZEROS = 254;
  localparam int ESF_RUN = 16;
  localparam int ESF_CLR_MAX = 14;
  localparam int RED_ZEROS = 192;
  localparam int RED_WIN = 112;
  localparam int RED_MIN_ONES = 14;

  typedef enum logic {
    RED_WAIT = 1'b0,
    RED_COUNT = 1'b1
  } tras_red_state_type;
endpackage

/* logic/tras_loop_detect.sv */
module tras_loop_detect #(
  parameter int RUN_BITS = 48
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // received bits
  input wire logic bit_en,
  input wire logic bit_in,
  // programmed code, right justified, length minus one
  input wire logic [7:0] code,
  input wire logic [2:0] code_len_m1,
  // result
  output logic detected
);
  localparam int RW = $clog2(RUN_BITS + 1);
  localparam logic [RW-1:0] RUN_MAX = RW'(RUN_BITS);

  logic [8:0] hist_q;
  logic [8:0] hist_d;
  logic [RW-1:0] run_q;
  logic [3:0] len;
  logic period_ok;
  logic phase_ok;

  // true when the newest n bits are some rotation of the code
  function automatic logic rot_match(input logic [8:0] h, input logic [7:0] c, input logic [3:0] n);
    logic hit;
    logic ok;
    logic [3:0] k;
    hit = 1'b0;
    for (int r = 0; r < 8; r++) begin
      ok = (r < n);
      for (int i = 0; i < 8; i++) begin
        k = 4'(i + r);
        if (k >= n) begin
          k = k - n;
        end
        if (i < n && h[i] != c[k[2:0]]) begin
          ok = 1'b0;
        end
      end
      hit = hit | ok;
    end
    return hit;
  endfunction

  assign len = {1'b0, code_len_m1} + 4'h1;
  assign hist_d = {hist_q[7:0], bit_in};
  assign period_ok = (hist_d[0] == hist_d[len]);
  assign phase_ok = rot_match(hist_d, code, len);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hist_q <= 9'h000;
    end else if (bit_en) begin
      hist_q <= hist_d;
    end
  end

  // any bit off the repeating code restarts the run
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= '0;
    end else if (bit_en) begin
      if (!(period_ok && phase_ok)) begin
        run_q <= '0;
      end else if (run_q != RUN_MAX) begin
        run_q <= run_q + 1'b1;
      end
    end
  end

  assign detected = (run_q == RUN_MAX);
endmodule

/* logic/tras_alarm_status.sv */
module tras_alarm_status #(
  parameter int BLUE_WIN = tras_pkg::BLUE_WIN_CYC,
  parameter int LOOP_BITS = tras_pkg::LOOP_RUN_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [tras_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tras_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tras_pkg::DATA_W-1:0] reg_rdata,
  // received line data, one bit per rx_bit_en
  input wire logic rx_bit_en,
  input wire logic rx_positive_data_in,
  input wire logic rx_negative_data_in,
  // framer indications
  input wire logic framer_in_sync,
  input wire logic rx_es_slip,
  input wire logic chan_bit2_en,
  input wire logic chan_bit2,
  input wire logic fbit12_en,
  input wire logic fbit12,
  input wire logic fdl_pattern_en,
  input wire logic fdl_is_00ff,
  // transmit clock monitor
  input wire logic tx_clock_input,
  // outputs
  output logic sync_clock_loss_pin,
  output logic tx_clock_from_rx,
  output logic framer_carrier_loss
);
  import tras_pkg::*;

  localparam int BW = $clog2(BLUE_WIN);
  localparam logic [BW-1:0] BLUE_LAST = BW'(BLUE_WIN - 1);

  logic [7:0] common_control_one_q;
  logic [7:0] tx_control_one_q;
  logic [7:0] rx_control_two_q;
  logic [7:0] loop_up_code_def_q;
  logic [7:0] loop_down_code_def_q;
  logic [7:0] loop_len_q;
  logic [7:0] rdata_q;
  logic [7:0] status;

  logic line_bit;
  logic line_zero;
  logic loop_up_detected;
  logic loop_down_detected;
  logic tx_clock_loss_q;
  logic rx_slip_event_q;
  logic blue_alarm_flag_q;
  logic yellow_alarm_flag;
  logic line_carrier_loss_q;
  logic rx_sync_loss;
  logic sync_clock_loss_pin_q;
  logic tx_clock_from_rx_q;

  assign line_bit = rx_positive_data_in | rx_negative_data_in;
  assign line_zero = !line_bit;
  assign rx_sync_loss = !framer_in_sync;

  // ---------------- registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      common_control_one_q <= RST_CTRL;
      tx_control_one_q <= RST_CTRL;
      rx_control_two_q <= RST_CTRL;
      loop_up_code_def_q <= RST_LOOP_CODE;
      loop_down_code_def_q <= RST_LOOP_CODE;
      loop_len_q <= RST_LOOP_LEN;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_COMMON_CTRL: common_control_one_q <= reg_wdata;
        ADDR_TX_CTRL: tx_control_one_q <= reg_wdata;
        ADDR_RX_CTRL: rx_control_two_q <= reg_wdata;
        ADDR_LOOP_UP: loop_up_code_def_q <= reg_wdata;
        ADDR_LOOP_DOWN: loop_down_code_def_q <= reg_wdata;
        ADDR_LOOP_LEN: loop_len_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    status = 8'h00;
    status[ST_LOOP_UP] = loop_up_detected;
    status[ST_LOOP_DOWN] = loop_down_detected;
    status[ST_TX_CLK_LOSS] = tx_clock_loss_q;
    status[ST_SLIP] = rx_slip_event_q;
    status[ST_BLUE] = blue_alarm_flag_q;
    status[ST_YELLOW] = yellow_alarm_flag;
    status[ST_CARRIER] = line_carrier_loss_q;
    status[ST_SYNC] = rx_sync_loss;
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS: rdata_q <= status;
        ADDR_COMMON_CTRL: rdata_q <= common_control_one_q;
        ADDR_TX_CTRL: rdata_q <= tx_control_one_q;
        ADDR_RX_CTRL: rdata_q <= rx_control_two_q;
        ADDR_LOOP_UP: rdata_q <= loop_up_code_def_q;
        ADDR_LOOP_DOWN: rdata_q <= loop_down_code_def_q;
        ADDR_LOOP_LEN: rdata_q <= loop_len_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------- loop codes
  tras_loop_detect #(
    .RUN_BITS(LOOP_BITS)
  ) u_loop_up (
    .clk(clk),
    .rstn(rstn),
    .bit_en(rx_bit_en),
    .bit_in(line_bit),
    .code(loop_up_code_def_q),
    .code_len_m1(loop_len_q[LL_UP_LSB +: 3]),
    .detected(loop_up_detected)
  );

  tras_loop_detect #(
    .RUN_BITS(LOOP_BITS)
  ) u_loop_down (
    .clk(clk),
    .rstn(rstn),
    .bit_en(rx_bit_en),
    .bit_in(line_bit),
    .code(loop_down_code_def_q),
    .code_len_m1(loop_len_q[LL_DOWN_LSB +: 3]),
    .detected(loop_down_detected)
  );

  // ---------------- transmit clock monitor
  logic tx_clk_prev_q;
  logic [9:0] tx_idle_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_clk_prev_q <= 1'b0;
      tx_idle_q <= 10'h000;
      tx_clock_loss_q <= 1'b0;
    end else begin
      tx_clk_prev_q <= tx_clock_input;
      if (tx_clock_input != tx_clk_prev_q) begin
        tx_idle_q <= 10'h000;
        tx_clock_loss_q <= 1'b0;
      end else if (tx_idle_q == 10'(TX_LOSS_CYC - 1)) begin
        tx_clock_loss_q <= 1'b1;
      end else begin
        tx_idle_q <= tx_idle_q + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_clock_loss_pin_q <= 1'b0;
      tx_clock_from_rx_q <= 1'b0;
    end else begin
      sync_clock_loss_pin_q <= rx_sync_loss | (tx_clock_loss_q & common_control_one_q[CC_PIN_CLK_LOSS]);
      tx_clock_from_rx_q <= tx_clock_loss_q & tx_control_one_q[TC_FALLBACK];
    end
  end

  assign sync_clock_loss_pin = sync_clock_loss_pin_q;
  assign tx_clock_from_rx = tx_clock_from_rx_q;

  // ---------------- slip, held until the status register is read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_slip_event_q <= 1'b0;
    end else if (rx_es_slip) begin
      rx_slip_event_q <= 1'b1;
    end else if (reg_rd && reg_addr == ADDR_STATUS) begin
      rx_slip_event_q <= 1'b0;
    end
  end

  // ---------------- blue alarm over fixed 3 ms windows
  logic [BW-1:0] blue_tick_q;
  logic [2:0] blue_zeros_q;
  logic [2:0] blue_zeros_d;

  always_comb begin
    blue_zeros_d = blue_zeros_q;
    if (rx_bit_en && line_zero && blue_zeros_q != 3'h6) begin
      blue_zeros_d = blue_zeros_q + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blue_tick_q <= '0;
      blue_zeros_q <= 3'h0;
      blue_alarm_flag_q <= 1'b0;
    end else if (blue_tick_q == BLUE_LAST) begin
      blue_tick_q <= '0;
      blue_zeros_q <= 3'h0;
      // a framed signal carries far more zeros than the threshold
      blue_alarm_flag_q <= (blue_zeros_d <= 3'(BLUE_SET_MAX_ZEROS));
    end else begin
      blue_tick_q <= blue_tick_q + 1'b1;
      blue_zeros_q <= blue_zeros_d;
    end
  end

  // ---------------- yellow, bit 2 of 256 channels
  logic [7:0] yb_chan_q;
  logic [8:0] yb_zeros_q;
  logic [8:0] yb_zeros_d;
  logic yel_bit2_q;

  assign yb_zeros_d = yb_zeros_q + {8'h00, !chan_bit2};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      yb_chan_q <= 8'h00;
      yb_zeros_q <= 9'h000;
      yel_bit2_q <= 1'b0;
    end else if (chan_bit2_en) begin
      yb_chan_q <= yb_chan_q + 8'h01;
      if (yb_chan_q == 8'(YEL_CHANS - 1)) begin
        yb_zeros_q <= 9'h000;
        yel_bit2_q <= (yb_zeros_d >= 9'(YEL_MIN_ZEROS));
      end else begin
        yb_zeros_q <= yb_zeros_d;
      end
    end
  end

  // ---------------- yellow, twelfth framing bit
  logic f12_prev_q;
  logic yel_f12_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      f12_prev_q <= 1'b0;
      yel_f12_q <= 1'b0;
    end else if (fbit12_en) begin
      f12_prev_q <= fbit12;
      if (fbit12 && f12_prev_q) begin
        yel_f12_q <= 1'b1;
      end else if (!fbit12 && !f12_prev_q) begin
        yel_f12_q <= 1'b0;
      end
    end
  end

  // ---------------- yellow, ESF data link patterns
  logic [4:0] esf_run_q;
  logic [3:0] esf_blk_q;
  logic [4:0] esf_hits_q;
  logic [4:0] esf_hits_d;
  logic yel_esf_q;

  assign esf_hits_d = esf_hits_q + {4'h0, fdl_is_00ff};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      esf_run_q <= 5'h00;
      esf_blk_q <= 4'h0;
      esf_hits_q <= 5'h00;
      yel_esf_q <= 1'b0;
    end else if (fdl_pattern_en) begin
      esf_blk_q <= esf_blk_q + 4'h1;
      esf_hits_q <= (esf_blk_q == 4'hf) ? 5'h00 : esf_hits_d;
      if (!fdl_is_00ff) begin
        esf_run_q <= 5'h00;
      end else if (esf_run_q != 5'(ESF_RUN)) begin
        esf_run_q <= esf_run_q + 5'h01;
      end
      if (fdl_is_00ff && esf_run_q >= 5'(ESF_RUN - 1)) begin
        yel_esf_q <= 1'b1;
      end else if (esf_blk_q == 4'hf && esf_hits_d <= 5'(ESF_CLR_MAX)) begin
        yel_esf_q <= 1'b0;
      end
    end
  end

  // each detector runs all the time; the mode only picks the one shown
  always_comb begin
    if (rx_control_two_q[RC_ESF]) begin
      yellow_alarm_flag = yel_esf_q;
    end else if (rx_control_two_q[RC_YEL_F12]) begin
      yellow_alarm_flag = yel_f12_q;
    end else begin
      yellow_alarm_flag = yel_bit2_q;
    end
  end

  // ---------------- red alarm
  tras_red_state_type red_state_q;
  logic [7:0] red_zrun_q;
  logic [6:0] red_pos_q;
  logic [6:0] red_ones_q;
  logic [6:0] red_ones_d;

  assign red_ones_d = red_ones_q + {6'h00, line_bit};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      red_zrun_q <= 8'h00;
    end else if (rx_bit_en) begin
      if (line_bit) begin
        red_zrun_q <= 8'h00;
      end else if (red_zrun_q != 8'(RED_ZEROS)) begin
        red_zrun_q <= red_zrun_q + 8'h01;
      end
    end
  end

  // clear window opens at the first one seen while in alarm
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      red_state_q <= RED_WAIT;
      red_pos_q <= 7'h00;
      red_ones_q <= 7'h00;
      line_carrier_loss_q <= 1'b0;
    end else if (rx_bit_en) begin
      if (line_zero && red_zrun_q == 8'(RED_ZEROS - 1)) begin
        line_carrier_loss_q <= 1'b1;
        red_state_q <= RED_WAIT;
      end else begin
        case (red_state_q)
          RED_WAIT: begin
            if (line_carrier_loss_q && line_bit) begin
              red_state_q <= RED_COUNT;
              red_pos_q <= 7'h01;
              red_ones_q <= 7'h01;
            end
          end
          RED_COUNT: begin
            if (red_pos_q == 7'(RED_WIN - 1)) begin
              red_state_q <= RED_WAIT;
              if (red_ones_d >= 7'(RED_MIN_ONES)) begin
                line_carrier_loss_q <= 1'b0;
              end
            end else begin
              red_pos_q <= red_pos_q + 7'h01;
              red_ones_q <= red_ones_d;
            end
          end
          default: red_state_q <= RED_WAIT;
        endcase
      end
    end
  end

  assign framer_carrier_loss = line_carrier_loss_q;
endmodule

/* verif/tras_alarm_status_assertions.sv */
module tras_alarm_status_chk #(
  parameter int BLUE_WIN = tras_pkg::BLUE_WIN_CYC,
  parameter int LOOP_BITS = tras_pkg::LOOP_RUN_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // line and framer
  input wire logic rx_bit_en,
  input wire logic rx_positive_data_in,
  input wire logic rx_negative_data_in,
  input wire logic framer_in_sync,
  input wire logic rx_es_slip,
  input wire logic tx_clock_input,
  // outputs
  input wire logic sync_clock_loss_pin,
  input wire logic tx_clock_from_rx,
  input wire logic framer_carrier_loss
);
  import tras_pkg::*;
  logic fb_q, slip_q, line_bit, rd_st;
  logic [9:0] idle_q;
  logic [8:0] zrun_q;
  assign line_bit = rx_positive_data_in | rx_negative_data_in;
  assign rd_st = reg_rd && (reg_addr == ADDR_STATUS);
  // expected fallback enable and sticky slip
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fb_q <= 1'b0;
      slip_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_TX_CTRL) fb_q <= reg_wdata[TC_FALLBACK];
      slip_q <= rx_es_slip | (slip_q & ~rd_st);
    end
  end
  // cycles since the transmit clock last moved
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) idle_q <= 10'h0;
    else if ($changed(tx_clock_input)) idle_q <= 10'h0;
    else if (idle_q != 10'h3ff) idle_q <= idle_q + 10'h1;
  end
  // run of zero line bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) zrun_q <= 9'h0;
    else if (rx_bit_en) zrun_q <= line_bit ? 9'h0 : zrun_q + {8'h0, zrun_q != 9'h1ff};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  AST_SYNC_READ: assert property ($past(rd_st) |-> reg_rdata[ST_SYNC] == !$past(framer_in_sync))
    else $error("sync loss bit wrong");
  AST_SLIP_READ: assert property ($past(rd_st) |-> reg_rdata[ST_SLIP] == $past(slip_q))
    else $error("slip bit wrong");
  AST_PIN_SYNC: assert property (!framer_in_sync |-> ##[1:3] sync_clock_loss_pin)
    else $error("pin low during sync loss");
  AST_TX_RISE: assert property ($rose(tx_clock_from_rx) |->
    $past(fb_q) && idle_q >= 10'(TX_LOSS_CYC - 2) && idle_q <= 10'(TX_LOSS_CYC + 3))
    else $error("fallback at wrong moment");
  AST_TX_SET: assert property (fb_q && idle_q == 10'(TX_LOSS_CYC + 4) |-> tx_clock_from_rx)
    else $error("fallback missing");
  AST_RED_SET: assert property (rx_bit_en && !line_bit && zrun_q == 9'(RED_ZEROS - 1)
    |-> ##[1:3] framer_carrier_loss)
    else $error("carrier loss not set");
  AST_RED_RISE: assert property ($rose(framer_carrier_loss) |-> zrun_q >= 9'(RED_ZEROS))
    else $error("carrier loss set early");
endmodule

/* verif/tras_line_model.sv */
module tras_line_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pattern, sent from bit plen down to bit 0, repeated
  input wire logic [7:0] pat,
  input wire logic [2:0] plen,
  input wire logic tx_run,
  // line and transmit clock
  output logic rx_bit_en,
  output logic rx_positive_data_in,
  output logic rx_negative_data_in,
  output logic tx_clock_input
);
  logic [1:0] slot_q;
  logic [2:0] idx_q;
  logic [4:0] tck_q;
  logic pol_q, bit_v;
  assign bit_v = pat[idx_q];
  // a bit every fourth cycle, marks on alternating rails
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_q <= 2'h0;
      idx_q <= 3'h0;
      pol_q <= 1'b0;
      rx_bit_en <= 1'b0;
      rx_positive_data_in <= 1'b0;
      rx_negative_data_in <= 1'b0;
    end else begin
      slot_q <= slot_q + 2'h1;
      rx_bit_en <= (slot_q == 2'h3);
      if (slot_q == 2'h3) begin
        idx_q <= (idx_q == 3'h0 || idx_q > plen) ? plen : idx_q - 3'h1;
        pol_q <= pol_q ^ bit_v;
        rx_positive_data_in <= bit_v & pol_q;
        rx_negative_data_in <= bit_v & ~pol_q;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tck_q <= 5'h0;
      tx_clock_input <= 1'b0;
    end else if (tx_run) begin
      tck_q <= tck_q + 5'h1;
      if (tck_q == 5'h1f) tx_clock_input <= ~tx_clock_input;
    end
  end
endmodule

/* verif/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tras_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, framer_in_sync, rx_es_slip, tx_run, rx_bit_en;
  logic chan_bit2_en, chan_bit2, fbit12_en, fbit12, fdl_pattern_en, fdl_is_00ff;
  logic rx_positive_data_in, rx_negative_data_in, tx_clock_input;
  logic sync_clock_loss_pin, tx_clock_from_rx, framer_carrier_loss;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pat, rd_v;
  logic [2:0] plen;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  tras_alarm_status #(.BLUE_WIN(64), .LOOP_BITS(16)) u_tras_alarm_status (.clk, .rstn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_bit_en, .rx_positive_data_in, .rx_negative_data_in,
    .framer_in_sync, .rx_es_slip, .chan_bit2_en, .chan_bit2, .fbit12_en, .fbit12, .fdl_pattern_en,
    .fdl_is_00ff, .tx_clock_input, .sync_clock_loss_pin, .tx_clock_from_rx, .framer_carrier_loss);
  tras_line_model u_tras_line_model (.clk, .rstn, .pat, .plen, .tx_run, .rx_bit_en,
    .rx_positive_data_in, .rx_negative_data_in, .tx_clock_input);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask
  task automatic st(int b, logic v);
    rd(ADDR_STATUS);
    chk({7'h0, rd_v[b]}, {7'h0, v});
  endtask
  task automatic send(logic [7:0] p, logic [2:0] l, int nbits);
    @(posedge clk);
    pat <= p;
    plen <= l;
    repeat (nbits * 4) @(posedge clk);
    #1;
  endtask
  // k selects bit 2, twelfth framing bit or data link pattern
  task automatic pulse(int k, int n, logic v);
    repeat (n) begin
      @(posedge clk);
      {chan_bit2_en, fbit12_en, fdl_pattern_en} <= 3'h4 >> k;
      {chan_bit2, fbit12, fdl_is_00ff} <= {3{v}};
    end
    @(posedge clk);
    {chan_bit2_en, fbit12_en, fdl_pattern_en} <= 3'h0;
  endtask
  task automatic t_regs();
    for (int a = 8'h70; a <= 8'h75; a++) begin
      rd(8'(a));
      chk(rd_v, 8'h00);
    end
    rd(8'hff);
    chk(rd_v, 8'h00);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS);
    chk(rd_v & 8'h15, 8'h00);
  endtask
  task automatic t_sync_slip();
    @(posedge clk);
    framer_in_sync <= 1'b0;
    rx_es_slip <= 1'b1;
    @(posedge clk);
    rx_es_slip <= 1'b0;
    rd(ADDR_STATUS);
    chk(rd_v & 8'h11, 8'h11);
    chk({7'h0, sync_clock_loss_pin}, 8'h01);
    @(posedge clk);
    framer_in_sync <= 1'b1;
    rd(ADDR_STATUS);
    chk(rd_v & 8'h11, 8'h00);
    chk({7'h0, sync_clock_loss_pin}, 8'h00);
    // slip arriving with a status read must survive that read
    @(posedge clk);
    rx_es_slip <= 1'b1;
    reg_rd <= 1'b1;
    reg_addr <= ADDR_STATUS;
    @(posedge clk);
    rx_es_slip <= 1'b0;
    reg_rd <= 1'b0;
    st(ST_SLIP, 1'b1);
  endtask
  task automatic t_tx();
    for (int e = 1; e >= 0; e--) begin
      wr(ADDR_COMMON_CTRL, {1'b0, 1'(e), 6'h0});
      wr(ADDR_TX_CTRL, {1'(e), 7'h0});
      @(posedge clk);
      tx_run <= 1'b0;
      repeat (TX_LOSS_CYC + 40) @(posedge clk);
      #1;
      chk({6'h0, sync_clock_loss_pin, tx_clock_from_rx}, {6'h0, 1'(e), 1'(e)});
      st(ST_TX_CLK_LOSS, 1'b1);
      @(posedge clk);
      tx_run <= 1'b1;
      repeat (40) @(posedge clk);
      st(ST_TX_CLK_LOSS, 1'b0);
    end
  endtask
  task automatic t_red();
    send(8'h00, 3'h0, 190);
    chk({7'h0, framer_carrier_loss}, 8'h00);
    send(8'h00, 3'h0, 6);
    st(ST_CARRIER, 1'b1);
    send(8'h01, 3'h0, 100);
    chk({7'h0, framer_carrier_loss}, 8'h01);
    send(8'h01, 3'h0, 16);
    st(ST_CARRIER, 1'b0);
  endtask
  task automatic t_blue();
    send(8'hfe, 3'h7, 48);
    st(ST_BLUE, 1'b1);
    chk(rd_v & 8'h09, 8'h08);
    send(8'hf8, 3'h7, 48);
    st(ST_BLUE, 1'b0);
  endtask
  task automatic t_yellow();
    pulse(0, 256, 1'b0);
    st(ST_YELLOW, 1'b1);
    pulse(0, 254, 1'b0);
    pulse(0, 2, 1'b1);
    st(ST_YELLOW, 1'b1);
    pulse(0, 253, 1'b0);
    pulse(0, 3, 1'b1);
    st(ST_YELLOW, 1'b0);
    wr(ADDR_RX_CTRL, 8'h04);
    for (int i = 0; i < 4; i++) begin
      pulse(1, 1, i < 2);
      st(ST_YELLOW, 1'(4'b0110 >> i));
    end
    wr(ADDR_RX_CTRL, 8'h08);
    pulse(2, 15, 1'b1);
    st(ST_YELLOW, 1'b0);
    pulse(2, 1, 1'b1);
    st(ST_YELLOW, 1'b1);
    pulse(2, 15, 1'b1);
    pulse(2, 1, 1'b0);
    st(ST_YELLOW, 1'b1);
    pulse(2, 14, 1'b1);
    pulse(2, 2, 1'b0);
    st(ST_YELLOW, 1'b0);
  endtask
  task automatic t_loop();
    wr(ADDR_LOOP_UP, 8'h01);
    wr(ADDR_LOOP_DOWN, 8'h01);
    wr(ADDR_LOOP_LEN, 8'h14);
    for (int i = 0; i < 3; i++) begin
      send(8'h01, 3'(4 - 2 * i), 40);
      rd(ADDR_STATUS);
      chk(rd_v & 8'hc0, 8'hc0 & (8'h80 >> i));
    end
  endtask
  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, rx_es_slip, chan_bit2_en, chan_bit2, fbit12_en, fbit12} = 7'h0;
    {fdl_pattern_en, fdl_is_00ff} = 2'h0;
    framer_in_sync = 1'b1;
    tx_run = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pat = 8'h01;
    plen = 3'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_sync_slip();
    t_tx();
    t_red();
    t_blue();
    t_yellow();
    t_loop();
    test_done();
  end
endmodule
bind tras_alarm_status tras_alarm_status_chk #(.BLUE_WIN(BLUE_WIN), .LOOP_BITS(LOOP_BITS)) u_chk (.clk, .rstn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_bit_en, .rx_positive_data_in, .rx_negative_data_in,
  .framer_in_sync, .rx_es_slip, .tx_clock_input, .sync_clock_loss_pin, .tx_clock_from_rx, .framer_carrier_loss);
